// file: design/cpu_flag_pkg.sv
// constants, encodings and carriers for the status and control flag logic
// What this block does
// RULE_01: zero flag set when byte/word result zero
// RULE_02: sign flag copies result bit 7 or 15
// RULE_03: add/sub overflow from top two carries differing
// RULE_04: byte multiply overflow from high accumulator byte
// RULE_05: word multiply overflow from extension word
// RULE_06: immediate multiply overflow when product exceeds 16 bits
// RULE_07: division always clears overflow
// RULE_08: logical operations always clear overflow
// RULE_09: one-bit left shift overflow: carry differs from msb
// RULE_10: one-bit right shift overflow: msb differs below
// RULE_11: single-step flag traps vector 1 per instruction
// RULE_12: interrupt accept flag set/cleared by instructions
// RULE_13: step-down flag picks block transfer direction
// RULE_14: mode flag set natively, cleared entering emulation
// RULE_15: mode flag write protection on reset/leave
// RULE_16: repeat counter counts repeats and shift positions
// RULE_17: instruction pointer increments per byte, loads branches
// RULE_18: operand address ready within two clocks
// RULE_19: add/sub carry from bit 7/15, inc/dec keep
// RULE_20: parity flag set on even low-byte ones
// RULE_21: nibble carry from low nibble carry or borrow
// RULE_22: undefined flags stay unchanged
package cpu_flag_pkg;

    localparam int DATA_W = 16;

    // status word bit positions
    localparam int FLAG_CARRY     = 0;
    localparam int FLAG_PARITY    = 2;
    localparam int FLAG_NIBBLE    = 4;
    localparam int FLAG_ZERO      = 6;
    localparam int FLAG_SIGN      = 7;
    localparam int FLAG_STEP      = 8;
    localparam int FLAG_IRQ       = 9;
    localparam int FLAG_STEP_DOWN = 10;
    localparam int FLAG_OVF       = 11;
    localparam int FLAG_MODE      = 15;

    localparam logic [15:0] STATUS_RESET    = 16'hF002;
    localparam logic [15:0] STATUS_FIXED    = 16'h7002;
    localparam logic [15:0] STATUS_WRITABLE = 16'h8FD5;
    localparam logic [15:0] STATUS_LOW_MASK = 16'h00D5;

    // register port offsets
    localparam logic [3:0] REG_STATUS   = 4'h0;
    localparam logic [3:0] REG_REPEAT   = 4'h1;
    localparam logic [3:0] REG_POINTER  = 4'h2;
    localparam logic [3:0] REG_DATA_PTR = 4'h3;
    localparam logic [3:0] REG_CONTROL  = 4'h4;

    localparam int          EA_CYCLES   = 2;
    localparam logic [7:0]  STEP_VECTOR = 8'h01;
    localparam logic [15:0] ONE_WORD    = 16'h0001;

    typedef enum logic [3:0] {
        OP_ADD   = 4'h0,
        OP_SUB   = 4'h1,
        OP_INC   = 4'h2,
        OP_DEC   = 4'h3,
        OP_LOGIC = 4'h4,
        OP_SHL1  = 4'h5,
        OP_SHR1  = 4'h6,
        OP_SHLN  = 4'h7,
        OP_SHRN  = 4'h8,
        OP_MULU  = 4'h9,
        OP_MULS  = 4'hA,
        OP_MULI  = 4'hB,
        OP_DIV   = 4'hC
    } alu_op_e;

    typedef enum logic [1:0] {
        FN_AND = 2'h0,
        FN_OR  = 2'h1,
        FN_XOR = 2'h2
    } logic_fn_e;

    typedef enum logic [3:0] {
        CMD_IRQ_ON       = 4'h0,
        CMD_IRQ_OFF      = 4'h1,
        CMD_STEP_DOWN_S  = 4'h2,
        CMD_STEP_DOWN_C  = 4'h3,
        CMD_CARRY_SET    = 4'h4,
        CMD_CARRY_CLEAR  = 4'h5,
        CMD_CARRY_INVERT = 4'h6,
        CMD_ENTER_EMUL   = 4'h7,
        CMD_LEAVE_EMUL   = 4'h8,
        CMD_NATIVE_CALL  = 4'h9,
        CMD_IRQ_RETURN   = 4'hA,
        CMD_FLAGS_POP    = 4'hB,
        CMD_IRQ_TAKEN    = 4'hC
    } ctl_cmd_e;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_RUN  = 2'b01
    } shift_state_e;

    typedef struct packed {
        logic        valid;
        alu_op_e     op;
        logic        word;
        logic_fn_e   fn;
        logic [15:0] a;
        logic [15:0] b;
    } alu_req_s;

    typedef struct packed {
        logic        valid;
        ctl_cmd_e    cmd;
        logic [15:0] image;
    } ctl_req_s;

endpackage

// file: design/cpu_status_flag_logic.sv
// status word, repeat counter, instruction pointer and operand address unit
`timescale 1ns/1ns
module cpu_status_flag_logic
    import cpu_flag_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // operation results and control instructions
    input  wire alu_req_s    alu_in,
    input  wire ctl_req_s    ctl_in,
    input  wire logic        instr_done_in,
    input  wire logic        rep_step_in,
    // instruction pointer
    input  wire logic        queue_byte_in,
    input  wire logic        branch_load_in,
    input  wire logic [15:0] branch_target_in,
    // operand address
    input  wire logic        ea_start_in,
    input  wire logic [15:0] ea_base_in,
    input  wire logic [15:0] ea_index_in,
    input  wire logic [15:0] ea_disp_in,
    // register port
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rd_data_out,
    // state
    output logic      [15:0] status_word_out,
    output logic      [15:0] result_out,
    output logic      [15:0] ext_acc_word_out,
    output logic      [15:0] repeat_counter_out,
    output logic      [15:0] instr_pointer_out,
    output logic      [15:0] data_pointer_out,
    output logic             ea_done_out,
    output logic             shift_busy_out,
    output logic             step_irq_out,
    output logic      [7:0]  step_vector_out
);

    logic [15:0]  status_word;
    logic [15:0]  next_status;
    logic         mode_lock;
    logic [15:0]  repeat_counter;
    logic [15:0]  next_counter;
    logic [15:0]  instr_pointer;
    shift_state_e shift_state;
    logic [15:0]  shift_work;
    logic         shift_left;
    logic         shift_word;
    logic         shift_cy;
    logic [15:0]  ea_partial;
    logic [15:0]  ea_disp;
    logic         ea_stage;

    // flag triple of a result: zero, sign, parity
    function automatic logic [2:0] zsp(input logic [15:0] r,
                                       input logic w);
        logic z;
        logic s;
        z = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
        s = w ? r[15] : r[7];
        zsp = {z, s, ~^r[7:0]};
    endfunction

    wire alu_op_e op    = alu_in.op;
    wire          word  = alu_in.word;
    wire [15:0]   a     = alu_in.a;
    wire          fire  = alu_in.valid;

    // adder, shared by add, subtract, increment and decrement
    wire          sub_op = (op == OP_SUB) || (op == OP_DEC);
    wire          step_op = (op == OP_INC) || (op == OP_DEC);
    wire [15:0]   b_eff  = step_op ? ONE_WORD : alu_in.b;
    wire [15:0]   add_b  = sub_op ? ~b_eff : b_eff;
    wire [16:0]   full   = {1'b0, a} + {1'b0, add_b}
                         + {16'h0000, sub_op};
    wire [16:0]   ci     = {1'b0, a ^ add_b} ^ full;
    wire          arith_cy = (word ? ci[16] : ci[8]) ^ sub_op;
    wire          arith_ov = word ? ci[16] ^ ci[15] : ci[8] ^ ci[7];
    wire          arith_nb = ci[4] ^ sub_op;
    wire arith_op = (op == OP_ADD) || (op == OP_SUB) || step_op;

    // logical unit
    wire [15:0] logic_res = (alu_in.fn == FN_AND) ? a & alu_in.b :
                            (alu_in.fn == FN_OR)  ? a | alu_in.b :
                                                    a ^ alu_in.b;

    // one-bit left and right shifts, each shifting in a zero
    wire [15:0] shl_res = {a[14:0], 1'b0};
    wire        shl_cy  = word ? a[15] : a[7];
    wire        shl_ov  = shl_cy ^ (word ? shl_res[15] : shl_res[7]);
    wire [15:0] shr_res = word ? {1'b0, a[15:1]}
                               : {8'h00, 1'b0, a[7:1]};
    wire        shr_ov  = word ? shr_res[15] ^ shr_res[14]
                               : shr_res[7] ^ shr_res[6];

    // multiplier
    wire        [15:0] mul_bu = a[7:0] * alu_in.b[7:0];
    wire signed [15:0] mul_bs = $signed(a[7:0]) * $signed(alu_in.b[7:0]);
    wire        [31:0] mul_wu = a * alu_in.b;
    wire signed [31:0] mul_ws = $signed(a) * $signed(alu_in.b);
    wire signed [23:0] mul_im = $signed(a) * $signed(alu_in.b[7:0]);
    wire mulu_ov = word ? |mul_wu[31:16] : |mul_bu[15:8];
    wire muls_ov = word ? mul_ws[31:16] != {16{mul_ws[15]}}
                        : mul_bs[15:8] != {8{mul_bs[7]}};
    wire muli_ov = mul_im[23:15] != {9{mul_im[15]}};

    // multi-bit shift stepping
    wire [4:0]  shift_count = alu_in.b[4:0];
    wire        shift_start = fire && (op == OP_SHLN || op == OP_SHRN)
                            && shift_state == SH_IDLE;
    wire        shift_run   = shift_state == SH_RUN;
    wire [15:0] shift_next  = shift_left ? {shift_work[14:0], 1'b0}
                            : shift_word ? {1'b0, shift_work[15:1]}
                            : {8'h00, 1'b0, shift_work[7:1]};
    wire        shift_out   = shift_left ? (shift_word ? shift_work[15]
                                                       : shift_work[7])
                                         : shift_work[0];
    wire        shift_last  = shift_run && repeat_counter == ONE_WORD;

    // register port decode
    wire wr_status  = wr_in && addr_in == REG_STATUS;
    wire wr_repeat  = wr_in && addr_in == REG_REPEAT;
    wire [15:0] rd_mux =
        (addr_in == REG_STATUS)   ? status_word :
        (addr_in == REG_REPEAT)   ? repeat_counter :
        (addr_in == REG_POINTER)  ? instr_pointer :
        (addr_in == REG_DATA_PTR) ? data_pointer_out :
        (addr_in == REG_CONTROL)  ? {14'h0000, shift_run, mode_lock} :
                                    16'h0000;

    wire [15:0] image = (ctl_in.image & STATUS_WRITABLE) | STATUS_FIXED;

    // next status word: results first, then instructions, then software
    always_comb
    begin
        next_status = status_word;
        if (fire)
        begin
            case (op)
                OP_ADD, OP_SUB, OP_INC, OP_DEC:
                begin
                    {next_status[FLAG_ZERO], next_status[FLAG_SIGN],
                     next_status[FLAG_PARITY]} = zsp(full[15:0], word); // RULE_01 RULE_02 RULE_20
                    next_status[FLAG_OVF]    = arith_ov; // RULE_03
                    next_status[FLAG_NIBBLE] = arith_nb; // RULE_21
                    if (!step_op)
                        next_status[FLAG_CARRY] = arith_cy; // RULE_19
                end
                OP_LOGIC:
                begin
                    {next_status[FLAG_ZERO], next_status[FLAG_SIGN],
                     next_status[FLAG_PARITY]} = zsp(logic_res, word); // RULE_01 RULE_02 RULE_20
                    next_status[FLAG_OVF]   = 1'b0; // RULE_08
                    next_status[FLAG_CARRY] = 1'b0;
                end
                OP_SHL1:
                begin
                    {next_status[FLAG_ZERO], next_status[FLAG_SIGN],
                     next_status[FLAG_PARITY]} = zsp(shl_res, word);
                    next_status[FLAG_CARRY] = shl_cy;
                    next_status[FLAG_OVF]   = shl_ov; // RULE_09
                end
                OP_SHR1:
                begin
                    {next_status[FLAG_ZERO], next_status[FLAG_SIGN],
                     next_status[FLAG_PARITY]} = zsp(shr_res, word);
                    next_status[FLAG_CARRY] = a[0];
                    next_status[FLAG_OVF]   = shr_ov; // RULE_10
                end
                OP_MULU:
                begin
                    next_status[FLAG_OVF]   = mulu_ov; // RULE_04 RULE_05
                    next_status[FLAG_CARRY] = mulu_ov;
                end
                OP_MULS:
                begin
                    next_status[FLAG_OVF]   = muls_ov; // RULE_04 RULE_05
                    next_status[FLAG_CARRY] = muls_ov;
                end
                OP_MULI:
                begin
                    next_status[FLAG_OVF]   = muli_ov; // RULE_06
                    next_status[FLAG_CARRY] = muli_ov;
                end
                OP_DIV:
                    next_status[FLAG_OVF] = 1'b0; // RULE_07
                default:
                    next_status = status_word; // RULE_22
            endcase
        end
        if (shift_last)
        begin
            // overflow is left alone after a multi-bit shift
            {next_status[FLAG_ZERO], next_status[FLAG_SIGN],
             next_status[FLAG_PARITY]} = zsp(shift_next, shift_word); // RULE_22
            next_status[FLAG_CARRY] = shift_out;
        end
        if (ctl_in.valid)
        begin
            case (ctl_in.cmd)
                CMD_IRQ_ON:       next_status[FLAG_IRQ] = 1'b1; // RULE_12
                CMD_IRQ_OFF:      next_status[FLAG_IRQ] = 1'b0; // RULE_12
                CMD_STEP_DOWN_S:  next_status[FLAG_STEP_DOWN] = 1'b1; // RULE_13
                CMD_STEP_DOWN_C:  next_status[FLAG_STEP_DOWN] = 1'b0; // RULE_13
                CMD_CARRY_SET:    next_status[FLAG_CARRY] = 1'b1;
                CMD_CARRY_CLEAR:  next_status[FLAG_CARRY] = 1'b0;
                CMD_CARRY_INVERT: next_status[FLAG_CARRY] = ~status_word[FLAG_CARRY];
                CMD_ENTER_EMUL:   next_status[FLAG_MODE] = 1'b0; // RULE_14
                CMD_NATIVE_CALL:  next_status[FLAG_MODE] = 1'b1; // RULE_14
                CMD_IRQ_TAKEN:
                begin
                    next_status[FLAG_IRQ]  = 1'b0;
                    next_status[FLAG_STEP] = 1'b0;
                end
                default:
                begin
                    // single-step flag only becomes live through a restore
                    next_status = image; // RULE_11
                    if (ctl_in.cmd == CMD_LEAVE_EMUL)
                        next_status[FLAG_MODE] = 1'b1; // RULE_14
                    else if (mode_lock)
                        next_status[FLAG_MODE] = status_word[FLAG_MODE]; // RULE_15
                end
            endcase
        end
        if (wr_status)
            next_status = (next_status & ~STATUS_LOW_MASK)
                        | (wr_data_in & STATUS_LOW_MASK);
    end

    // repeat counter: shift steps take priority over repeat steps
    always_comb
    begin
        next_counter = repeat_counter;
        if (wr_repeat)
            next_counter = wr_data_in;
        else if (shift_start)
            next_counter = {11'h000, shift_count}; // RULE_16
        else if (shift_run)
            next_counter = repeat_counter - ONE_WORD; // RULE_16
        else if (rep_step_in && repeat_counter != 16'h0000)
            next_counter = repeat_counter - ONE_WORD; // RULE_16
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            status_word    <= STATUS_RESET; // RULE_14
            mode_lock      <= 1'b1; // RULE_15
            repeat_counter <= 16'h0000;
        end
        else
        begin
            status_word    <= next_status;
            repeat_counter <= next_counter;
            if (ctl_in.valid && ctl_in.cmd == CMD_LEAVE_EMUL)
                mode_lock <= 1'b1; // RULE_15
            else if (ctl_in.valid && ctl_in.cmd == CMD_ENTER_EMUL)
                mode_lock <= 1'b0; // RULE_15
        end
    end

    // multi-bit shift sequencer, one position per clock
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            shift_state <= SH_IDLE;
            shift_work  <= 16'h0000;
            shift_left  <= 1'b0;
            shift_word  <= 1'b0;
        end
        else
        begin
            case (shift_state)
                SH_IDLE:
                    if (shift_start)
                    begin
                        shift_work  <= a;
                        shift_left  <= op == OP_SHLN;
                        shift_word  <= word;
                        if (shift_count != 5'h00)
                            shift_state <= SH_RUN;
                    end
                SH_RUN:
                begin
                    shift_work <= shift_next;
                    if (shift_last)
                        shift_state <= SH_IDLE;
                end
                default:
                    shift_state <= SH_IDLE;
            endcase
        end
    end

    // result path
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            result_out       <= 16'h0000;
            ext_acc_word_out <= 16'h0000;
        end
        else if (shift_run)
            result_out <= shift_next;
        else if (fire)
        begin
            case (op)
                OP_LOGIC: result_out <= logic_res;
                OP_SHL1:  result_out <= shl_res;
                OP_SHR1:  result_out <= shr_res;
                OP_MULU:
                begin
                    result_out       <= word ? mul_wu[15:0] : mul_bu;
                    ext_acc_word_out <= mul_wu[31:16];
                end
                OP_MULS:
                begin
                    result_out       <= word ? mul_ws[15:0] : mul_bs;
                    ext_acc_word_out <= mul_ws[31:16];
                end
                OP_MULI:  result_out <= mul_im[15:0];
                default:  result_out <= full[15:0];
            endcase
        end
    end

    // instruction pointer; a branch load wins over a queue byte
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            instr_pointer <= 16'h0000;
        else if (branch_load_in)
            instr_pointer <= branch_target_in; // RULE_17
        else if (queue_byte_in)
            instr_pointer <= instr_pointer + ONE_WORD; // RULE_17
    end

    // operand address in two stages so the adder chain stays short
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ea_stage         <= 1'b0;
            ea_partial       <= 16'h0000;
            ea_disp          <= 16'h0000;
            data_pointer_out <= 16'h0000;
            ea_done_out      <= 1'b0;
        end
        else
        begin
            ea_stage    <= ea_start_in;
            ea_done_out <= ea_stage; // RULE_18
            if (ea_start_in)
            begin
                ea_partial <= ea_base_in + ea_index_in;
                ea_disp    <= ea_disp_in;
            end
            if (ea_stage)
                data_pointer_out <= ea_partial + ea_disp; // RULE_18
        end
    end

    // single-step trap and register read port
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            step_irq_out    <= 1'b0;
            step_vector_out <= 8'h00;
            rd_data_out     <= 16'h0000;
        end
        else
        begin
            step_irq_out <= instr_done_in && status_word[FLAG_STEP]; // RULE_11
            if (instr_done_in && status_word[FLAG_STEP])
                step_vector_out <= STEP_VECTOR; // RULE_11
            rd_data_out <= rd_in ? rd_mux : 16'h0000;
        end
    end

    assign status_word_out    = status_word;
    assign repeat_counter_out = repeat_counter;
    assign instr_pointer_out  = instr_pointer;
    assign shift_busy_out     = shift_run;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    wire quiet = !ctl_in.valid && !wr_status && !shift_run;

    property p_zero_flag;
        fire && arith_op && quiet
        |=> status_word[FLAG_ZERO] == ($past(word) ? result_out == 16'h0000
                                       : result_out[7:0] == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) // RULE_01
        else $error("zero flag wrong after arithmetic");

    property p_sign_flag;
        fire && op == OP_LOGIC && quiet
        |=> status_word[FLAG_SIGN] == ($past(word) ? result_out[15]
                                       : result_out[7]);
    endproperty
    a_sign_flag: assert property (p_sign_flag) // RULE_02
        else $error("sign flag wrong after logic op");

    property p_add_ovf;
        fire && op == OP_ADD && !word && quiet
        |=> status_word[FLAG_OVF] == ($past(a[7]) == $past(alu_in.b[7])
                                      && $past(a[7]) != result_out[7]);
    endproperty
    a_add_ovf: assert property (p_add_ovf) // RULE_03
        else $error("overflow wrong after byte add");

    property p_mulu_ovf;
        fire && op == OP_MULU && !word && quiet
        |=> status_word[FLAG_OVF] == (result_out[15:8] != 8'h00);
    endproperty
    a_mulu_ovf: assert property (p_mulu_ovf) // RULE_04
        else $error("overflow wrong after byte multiply");

    property p_div_clears;
        fire && op == OP_DIV && quiet |=> !status_word[FLAG_OVF];
    endproperty
    a_div_clears: assert property (p_div_clears) // RULE_07
        else $error("overflow not cleared by division");

    property p_inc_keeps_carry;
        fire && step_op && quiet |=> $stable(status_word[FLAG_CARRY]);
    endproperty
    a_inc_keeps_carry: assert property (p_inc_keeps_carry) // RULE_19
        else $error("carry changed by increment");

    property p_mode_locked;
        ctl_in.valid && ctl_in.cmd == CMD_FLAGS_POP && mode_lock
        && !wr_status |=> $stable(status_word[FLAG_MODE]);
    endproperty
    a_mode_locked: assert property (p_mode_locked) // RULE_15
        else $error("mode flag restored while protected");

    property p_step_trap;
        instr_done_in && status_word[FLAG_STEP]
        |=> step_irq_out && step_vector_out == STEP_VECTOR;
    endproperty
    a_step_trap: assert property (p_step_trap) // RULE_11
        else $error("single-step trap missing");

    property p_pointer_inc;
        queue_byte_in && !branch_load_in
        |=> instr_pointer == $past(instr_pointer) + ONE_WORD;
    endproperty
    a_pointer_inc: assert property (p_pointer_inc) // RULE_17
        else $error("instruction pointer did not advance");

    sequence s_ea_start;
        ea_start_in ##1 !ea_start_in;
    endsequence
    property p_ea_two;
        s_ea_start |=> ea_done_out;
    endproperty
    a_ea_two: assert property (p_ea_two) // RULE_18
        else $error("operand address not ready after two clocks");

endmodule

// file: tb/cpu_status_flag_logic_bench.sv
// self-checking bench: random flag operations against a behavioural model
`timescale 1ns/1ns
module cpu_status_flag_logic_bench;
    import cpu_flag_pkg::*;
    logic        clk_in = 0;
    logic        rstn_in = 0;
    alu_req_s    alu_in = '0;
    ctl_req_s    ctl_in = '0;
    logic        instr_done_in = 0, rep_step_in = 0, queue_byte_in = 0;
    logic        branch_load_in = 0, ea_start_in = 0, wr_in = 0, rd_in = 0;
    logic [15:0] branch_target_in = 0, ea_base_in = 0, ea_index_in = 0;
    logic [15:0] ea_disp_in = 0, wr_data_in = 0;
    logic [3:0]  addr_in = 0;
    logic [15:0] rd_data_out, status_word_out, result_out, ext_acc_word_out;
    logic [15:0] repeat_counter_out, instr_pointer_out, data_pointer_out;
    logic        ea_done_out, shift_busy_out, step_irq_out;
    logic [7:0]  step_vector_out;
    int          seed = 32'h6e4a_a3d1;
    int          failures = 0;
    int          compares = 0;
    int          k, n, j;
    logic        w, t, v;
    logic [15:0] a, b, x, y, mdl;
    logic [16:0] r;
    logic [31:0] p;
    alu_op_e     ops [9] = '{OP_ADD, OP_SUB, OP_LOGIC, OP_SHL1, OP_SHR1,
                             OP_DIV, OP_MULU, OP_INC, OP_DEC};

    cpu_status_flag_logic cpu_status_flag_logic_i (.clk_in, .rstn_in,
        .alu_in, .ctl_in, .instr_done_in, .rep_step_in, .queue_byte_in,
        .branch_load_in, .branch_target_in, .ea_start_in, .ea_base_in,
        .ea_index_in, .ea_disp_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
        .rd_data_out, .status_word_out, .result_out, .ext_acc_word_out,
        .repeat_counter_out, .instr_pointer_out, .data_pointer_out,
        .ea_done_out, .shift_busy_out, .step_irq_out, .step_vector_out);

    initial forever #50 clk_in = ~clk_in;

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one strobe cycle; read data are looked at in the cycle after it
    task automatic bus(input logic wr, input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk_in);
        {wr_in, rd_in, addr_in, wr_data_in} <= {wr, ~wr, ad, d};
        @(posedge clk_in);
        {wr_in, rd_in} <= 2'b00;
        #1;
    endtask

    task automatic ctl(input ctl_cmd_e c, input logic [15:0] im, input int bt,
                       input logic e);
        @(posedge clk_in);
        ctl_in <= '{1'b1, c, im};
        @(posedge clk_in);
        ctl_in.valid <= 1'b0;
        #1;
        chk("control flag", {15'h0000, status_word_out[bt]}, {15'h0000, e});
    endtask

    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // whole run is well under a thousand cycles
    initial
    begin
        #200_000;
        failures++;
        conclude();
    end

    initial
    begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        bus(0, REG_STATUS, 0);
        chk("status reset", rd_data_out, STATUS_RESET);
        bus(0, 4'h9, 0);
        chk("unmapped", rd_data_out, 16'h0000);
        bus(1, REG_REPEAT, 16'h1234);
        bus(0, REG_REPEAT, 0);
        chk("repeat counter", rd_data_out, 16'h1234);
        mdl = STATUS_RESET;
        repeat (80)
        begin
            k = {$random(seed)} % 9;
            j = k % 7;
            w = $random(seed);
            a = $random(seed);
            b = $random(seed) | 1;
            n = w ? 16 : 8;
            x = w ? a : {8'h00, a[7:0]};
            y = k > 6 ? ONE_WORD : w ? b : {8'h00, b[7:0]};
            @(posedge clk_in);
            alu_in <= '{1'b1, ops[k], w, FN_XOR, a, b};
            @(posedge clk_in);
            alu_in.valid <= 1'b0;
            #1;
            case (j)
                0: r = x + y;
                1: r = x - y;
                2: r = x ^ y;
                3: r = x << 1;
                default: r = x >> 1;
            endcase
            p = x * y;
            t = j == 1 ? x < y : k == 4 ? x[0] : r[n];
            v = j < 2 ? (x[n-1] ^ r[n-1]) & (x[n-1] ^ y[n-1] ^ (j == 0))
              : k == 3 ? t ^ r[n-1] : k == 4 ? r[n-1] ^ r[n-2]
              : k == 6 & (w ? p[31:16] != 0 : p[15:8] != 0);
            if (j < 2)
                mdl[4] = j ? x[3:0] < y[3:0] : x[3:0] + y[3:0] > 15;
            if (j < 5)
                mdl[7:0] = {r[n-1], w ? r[15:0] == 0 : r[7:0] == 0, 1'b0,
                            mdl[4], 1'b0, ~^r[7:0], 1'b1, k > 6 ? mdl[0] : t};
            if (k == 6)
                mdl[0] = v;
            mdl[11] = v;
            chk("flags", status_word_out, mdl);
            y = k == 6 | w ? 16'hffff : 16'h00ff;
            x = (k == 6 ? p[15:0] : r[15:0]) & y;
            if (k != 5)
                chk("result", result_out & y, x);
            if (k == 6 && w)
                chk("ext word", ext_acc_word_out, p[31:16]);
        end
        ctl(CMD_IRQ_ON, 0, 9, 1);
        ctl(CMD_IRQ_OFF, 0, 9, 0);
        ctl(CMD_STEP_DOWN_S, 0, 10, 1);
        ctl(CMD_STEP_DOWN_C, 0, 10, 0);
        ctl(CMD_FLAGS_POP, 0, 15, 1);
        ctl(CMD_ENTER_EMUL, 0, 15, 0);
        ctl(CMD_IRQ_RETURN, 16'h8000, 15, 1);
        ctl(CMD_ENTER_EMUL, 0, 15, 0);
        ctl(CMD_NATIVE_CALL, 0, 15, 1);
        ctl(CMD_ENTER_EMUL, 0, 15, 0);
        ctl(CMD_LEAVE_EMUL, 16'h8000, 15, 1);
        ctl(CMD_FLAGS_POP, 0, 15, 1);
        ctl(CMD_FLAGS_POP, 16'h0100, 8, 1);
        @(posedge clk_in);
        instr_done_in <= 1'b1;
        @(posedge clk_in);
        instr_done_in <= 1'b0;
        #1;
        chk("step", {step_irq_out, 7'h00, step_vector_out}, 16'h8001);
        ctl(CMD_IRQ_TAKEN, 0, 8, 0);
        @(posedge clk_in);
        {ea_start_in, ea_base_in, ea_index_in, ea_disp_in} <= {1'b1, a, b, x};
        @(posedge clk_in);
        {ea_start_in, queue_byte_in, rep_step_in} <= 3'b011;
        @(posedge clk_in);
        #1;
        chk("ea done", {ea_done_out, 15'h0000}, 16'h8000);
        chk("data pointer", data_pointer_out, a + b + x);
        repeat (2) @(posedge clk_in);
        {queue_byte_in, rep_step_in} <= 2'b00;
        bus(0, REG_POINTER, 0);
        chk("pointer", rd_data_out, 16'h0003);
        chk("repeat steps", repeat_counter_out, 16'h1231);
        @(posedge clk_in);
        {branch_load_in, queue_byte_in, branch_target_in} <= {2'b11, b};
        @(posedge clk_in);
        {branch_load_in, queue_byte_in} <= 2'b00;
        #1;
        chk("branch", instr_pointer_out, b);
        conclude();
    end
endmodule
